// File: smm_pkg.sv
// constants, types and helpers of the sensor-monitor mode sequencer
// assumes a 100 MHz system clock and 32-bit AHB-Lite register access
package smm_pkg;
   localparam int CLK_NS = 10;
   localparam int LOW_MIN_NS = 1800;
   localparam logic [7:0] LOW_CYC = 8'((LOW_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] SCL_PER_CONV = 5'd18;
   localparam logic [4:0] BUF_DEPTH = 5'd16;
   localparam logic [5:0] ACC_COUNT = 6'd16;
   localparam int OSC_SLOW_SHIFT = 4;
   localparam logic [2:0] OPM_AUTO = 3'h6;
   localparam logic [2:0] OPM_PREC = 3'h7;
   localparam logic [2:0] BFM_STOP = 3'h0;
   localparam logic [2:0] BFM_START = 3'h1;
   localparam logic [2:0] BFM_PRE = 3'h4;
   localparam logic [2:0] BFM_POST = 3'h6;
   localparam logic [1:0] SCAN_BOTH = 2'h3;
   localparam logic [7:0] REG_MODE = 8'h00;
   localparam logic [7:0] REG_SEQ = 8'h04;
   localparam logic [7:0] REG_BUFMODE = 8'h08;
   localparam logic [7:0] REG_CFG = 8'h0c;
   localparam logic [7:0] REG_TH0 = 8'h10;
   localparam logic [7:0] REG_TH1 = 8'h14;
   localparam logic [7:0] REG_LOWF = 8'h18;
   localparam logic [7:0] REG_HIGHF = 8'h1c;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_ACC = 8'h24;
   localparam logic [1:0] REG_BUF_PAGE = 2'h1;
   localparam int SEQUENCE_START_BIT_POS = 0;
   localparam int SEQUENCE_ABORT_BIT_POS = 1;
   localparam int CFG_ACCUMULATOR_ENABLE_POS = 6;
   localparam int CFG_OSC_POS = 5;
   localparam int CFG_CMP_EN_POS = 4;
   localparam int TH_HIGH_POS = 16;

   typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_RUN, ST_DONE} smm_state_t;

   typedef struct packed {
      smm_state_t st;
      logic [2:0] opMode;
      logic [2:0] bufMode;
      logic [1:0] scanSel;
      logic [1:0] alertEn;
      logic cmpEn;
      logic oscSel;
      logic accEn;
      logic [7:0] clkDiv;
      logic [1:0][11:0] hiTh;
      logic [1:0][11:0] loTh;
      logic [1:0] lowFlag;
      logic [1:0] highFlag;
      logic [15:0] calCnt;
      logic [11:0] tick;
      logic [4:0] sclCnt;
      logic [7:0] lowCnt;
      logic seqArmed;
      logic convStart;
      logic convChan;
      logic alert;
      logic busyRdy;
      logic sclHold;
      logic hready;
      logic [31:0] hrdata;
      logic aWrite;
      logic [7:0] aAddr;
      logic [3:0] wrPtr;
      logic [4:0] fill;
      logic trig;
      logic [1:0][15:0] acc;
      logic [5:0] accCnt;
      logic accValid;
   } smm_regs_t;

   function automatic logic isCh0Only(input logic [2:0] m);
      return m[2:1] == 2'b00;
   endfunction : isCh0Only

   function automatic logic isAutoSeq(input logic [2:0] m);
      return m[2:1] == 2'b10;
   endfunction : isAutoSeq

   function automatic logic [11:0] period(input logic [7:0] div, input logic osc);
      return osc ? 12'({4'h0, div} << OSC_SLOW_SHIFT) : {4'h0, div};
   endfunction : period

   function automatic logic nextChan(input logic cur, input logic [1:0] sel);
      return (sel == SCAN_BOTH) ? ~cur : (sel == 2'b10);
   endfunction : nextChan
endpackage : smm_pkg

// File: smm_sequencer.sv
// conversion sequencer, window flags, data buffer and accumulators
// assumes I2C framing decoded elsewhere into pulses, converter answers convDone
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module smm_sequencer #(
   parameter int CAL_CYCLES = 64
)(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // I2C events
   input wire logic i2cAddrRead,
   input wire logic i2cStopNack,
   input wire logic sclFall,
   input wire logic sclLow,
   output logic sclHoldLow,
   // converter
   output logic convStart,
   output logic convChan,
   input wire logic convDone,
   input wire logic [11:0] convData,
   // pins
   output logic alertOut,
   output logic busyRdy
);
   smm_pkg::smm_regs_t s;
   smm_pkg::smm_regs_t n;
   logic [11:0] mem [16];
   logic busRead;
   logic startReq;
   logic abortReq;
   logic doStore;
   logic hit;
   logic [1:0] clrLow;
   logic [1:0] clrHigh;
   logic [1:0] setLow;
   logic [1:0] setHigh;
   logic [31:0] rdVal;
   logic manual;
   logic firstCh;
   logic [5:0] accTarget;

   assign hreadyout = s.hready;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign sclHoldLow = s.sclHold;
   assign convStart = s.convStart;
   assign convChan = s.convChan;
   assign alertOut = s.alert;
   assign busyRdy = s.busyRdy;

   assign busRead = hsel & hready & htrans[1] & ~hwrite;
   assign firstCh = smm_pkg::isCh0Only(s.opMode) ? 1'b0 : (s.scanSel == 2'b10);
   assign manual = smm_pkg::isCh0Only(s.opMode) | smm_pkg::isAutoSeq(s.opMode);
   assign accTarget = (s.scanSel == smm_pkg::SCAN_BOTH) ? (smm_pkg::ACC_COUNT << 1) : smm_pkg::ACC_COUNT;

   always_comb
   begin
      rdVal = 32'h0;
      if (haddr[7:6] == smm_pkg::REG_BUF_PAGE)
      begin
         if (s.opMode != smm_pkg::OPM_PREC)
         begin
            rdVal = {20'h0, mem[haddr[5:2]]};
         end
      end
      else
      begin
         case (haddr[7:0])
            smm_pkg::REG_MODE: rdVal = {29'h0, s.opMode};
            smm_pkg::REG_SEQ: rdVal = {30'h0, s.seqArmed, s.st == smm_pkg::ST_RUN};
            smm_pkg::REG_BUFMODE: rdVal = {29'h0, s.bufMode};
            smm_pkg::REG_CFG: rdVal = {16'h0, s.clkDiv, 1'b0, s.accEn, s.oscSel, s.cmpEn, s.alertEn, s.scanSel};
            smm_pkg::REG_TH0: rdVal = {4'h0, s.hiTh[0], 4'h0, s.loTh[0]};
            smm_pkg::REG_TH1: rdVal = {4'h0, s.hiTh[1], 4'h0, s.loTh[1]};
            smm_pkg::REG_LOWF: rdVal = {30'h0, s.lowFlag};
            smm_pkg::REG_HIGHF: rdVal = {30'h0, s.highFlag};
            smm_pkg::REG_STATUS: rdVal = {23'h0, s.accValid, s.trig, s.fill, s.st};
            smm_pkg::REG_ACC: rdVal = {s.acc[1], s.acc[0]};
            default: rdVal = 32'h0;
         endcase
      end
   end

   always_comb
   begin
      n = s;
      n.convStart = 1'b0;
      n.hready = 1'b1;
      startReq = 1'b0;
      abortReq = 1'b0;
      doStore = 1'b0;
      clrLow = 2'b00;
      clrHigh = 2'b00;
      setLow = 2'b00;
      setHigh = 2'b00;
      hit = 1'b0;
      // data phase of a write taken in the previous cycle
      if (s.aWrite)
      begin
         case (s.aAddr)
            smm_pkg::REG_MODE:
            begin
               if (!(s.st == smm_pkg::ST_RUN && smm_pkg::isCh0Only(s.opMode)))
               begin
                  n.opMode = hwdata[2:0];
               end
            end
            smm_pkg::REG_SEQ:
            begin
               startReq = hwdata[smm_pkg::SEQUENCE_START_BIT_POS];
               abortReq = hwdata[smm_pkg::SEQUENCE_ABORT_BIT_POS];
            end
            smm_pkg::REG_BUFMODE: n.bufMode = hwdata[2:0];
            smm_pkg::REG_CFG:
            begin
               n.scanSel = hwdata[1:0];
               n.alertEn = hwdata[3:2];
               n.cmpEn = hwdata[smm_pkg::CFG_CMP_EN_POS];
               n.oscSel = hwdata[smm_pkg::CFG_OSC_POS];
               n.accEn = hwdata[smm_pkg::CFG_ACCUMULATOR_ENABLE_POS];
               n.clkDiv = hwdata[15:8];
            end
            smm_pkg::REG_TH0:
            begin
               n.loTh[0] = hwdata[11:0];
               n.hiTh[0] = hwdata[smm_pkg::TH_HIGH_POS +: 12];
            end
            smm_pkg::REG_TH1:
            begin
               n.loTh[1] = hwdata[11:0];
               n.hiTh[1] = hwdata[smm_pkg::TH_HIGH_POS +: 12];
            end
            smm_pkg::REG_LOWF: clrLow = hwdata[1:0];
            smm_pkg::REG_HIGHF: clrHigh = hwdata[1:0];
            default: n.aWrite = 1'b0;
         endcase
      end
      // address phase: zero wait states, read data registered here
      n.aWrite = hsel & hready & htrans[1] & hwrite;
      n.aAddr = haddr[7:0];
      if (busRead)
      begin
         n.hrdata = rdVal;
      end
      // SCL low time, saturating
      if (sclLow)
      begin
         n.lowCnt = (s.lowCnt == smm_pkg::LOW_CYC) ? s.lowCnt : s.lowCnt + 8'h1;
      end
      else
      begin
         n.lowCnt = 8'h0;
      end
      unique case (s.st)
         smm_pkg::ST_CAL:
         begin
            n.busyRdy = 1'b1;
            n.calCnt = s.calCnt + 16'h1;
            if (s.calCnt == 16'(CAL_CYCLES - 1))
            begin
               n.st = smm_pkg::ST_IDLE;
               n.busyRdy = 1'b0;
               n.opMode = 3'h0;
            end
         end
         smm_pkg::ST_IDLE, smm_pkg::ST_DONE:
         begin
            if (startReq && smm_pkg::isAutoSeq(s.opMode))
            begin
               n.seqArmed = 1'b1;
            end
            else if (startReq && s.opMode[2:1] == 2'b11)
            begin
               n.st = smm_pkg::ST_RUN;
               n.convStart = 1'b1;
               n.convChan = firstCh;
               n.tick = smm_pkg::period(s.clkDiv, s.oscSel);
               n.wrPtr = 4'h0;
               n.fill = 5'h0;
               n.trig = 1'b0;
               n.acc = '0;
               n.accCnt = 6'h0;
               n.accValid = 1'b0;
               n.busyRdy = s.opMode == smm_pkg::OPM_PREC;
            end
            if (i2cAddrRead && (smm_pkg::isCh0Only(s.opMode) || (smm_pkg::isAutoSeq(s.opMode) && s.seqArmed)))
            begin
               n.st = smm_pkg::ST_RUN;
               n.convStart = 1'b1;
               n.convChan = firstCh;
               n.sclCnt = 5'h0;
            end
         end
         smm_pkg::ST_RUN:
         begin
            if (manual)
            begin
               if (sclFall)
               begin
                  if (s.sclCnt == smm_pkg::SCL_PER_CONV - 5'h1)
                  begin
                     n.sclCnt = 5'h0;
                     n.convStart = 1'b1;
                     n.convChan = smm_pkg::isCh0Only(s.opMode) ? 1'b0 : smm_pkg::nextChan(s.convChan, s.scanSel);
                  end
                  else
                  begin
                     n.sclCnt = s.sclCnt + 5'h1;
                  end
               end
               if (smm_pkg::isCh0Only(s.opMode) && i2cStopNack)
               begin
                  n.st = smm_pkg::ST_IDLE;
               end
               if (smm_pkg::isAutoSeq(s.opMode) && (abortReq || busRead))
               begin
                  n.st = smm_pkg::ST_IDLE;
                  n.seqArmed = 1'b0;
               end
            end
            else
            begin
               if (convDone && s.opMode == smm_pkg::OPM_AUTO)
               begin
                  if (s.cmpEn && s.alertEn[s.convChan])
                  begin
                     setHigh[s.convChan] = convData > s.hiTh[s.convChan];
                     setLow[s.convChan] = convData < s.loTh[s.convChan];
                  end
                  hit = |{setHigh, setLow};
                  unique case (s.bufMode)
                     smm_pkg::BFM_PRE:
                     begin
                        doStore = 1'b1;
                        if (hit)
                        begin
                           n.st = smm_pkg::ST_DONE;
                        end
                     end
                     smm_pkg::BFM_POST:
                     begin
                        doStore = s.trig | hit;
                        n.trig = s.trig | hit;
                        if (doStore && s.fill == smm_pkg::BUF_DEPTH - 5'h1)
                        begin
                           n.st = smm_pkg::ST_DONE;
                        end
                     end
                     smm_pkg::BFM_START:
                     begin
                        doStore = 1'b1;
                        if (s.fill == smm_pkg::BUF_DEPTH - 5'h1)
                        begin
                           n.st = smm_pkg::ST_DONE;
                        end
                     end
                     smm_pkg::BFM_STOP: doStore = 1'b1;
                     default: doStore = 1'b0;
                  endcase
               end
               if (convDone && s.opMode == smm_pkg::OPM_PREC && s.accEn)
               begin
                  n.acc[s.convChan] = s.acc[s.convChan] + {4'h0, convData};
                  n.accCnt = s.accCnt + 6'h1;
                  if (n.accCnt == accTarget)
                  begin
                     n.st = smm_pkg::ST_DONE;
                     n.accValid = 1'b1;
                     n.busyRdy = 1'b0;
                  end
               end
               if (abortReq)
               begin
                  n.st = smm_pkg::ST_IDLE;
                  n.accValid = 1'b0;
                  n.busyRdy = 1'b0;
               end
               if (n.st == smm_pkg::ST_RUN)
               begin
                  if (s.tick == 12'h0)
                  begin
                     n.tick = smm_pkg::period(s.clkDiv, s.oscSel);
                     n.convStart = 1'b1;
                     n.convChan = smm_pkg::nextChan(s.convChan, s.scanSel);
                  end
                  else
                  begin
                     n.tick = s.tick - 12'h1;
                  end
               end
            end
         end
      endcase
      if (doStore)
      begin
         n.wrPtr = s.wrPtr + 4'h1;
         n.fill = (s.fill == smm_pkg::BUF_DEPTH) ? s.fill : s.fill + 5'h1;
      end
      n.lowFlag = (s.lowFlag & ~clrLow) | setLow;
      n.highFlag = (s.highFlag & ~clrHigh) | setHigh;
      n.alert = |{n.lowFlag, n.highFlag};
      // hold SCL low at conversion boundary
      n.sclHold = (s.st == smm_pkg::ST_RUN) && manual && sclLow && (s.sclCnt == 5'h0) &&
                  (s.lowCnt < smm_pkg::LOW_CYC - 8'h1);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.busyRdy <= 1'b1;
         s.hready <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // buffer storage has no reset; fill tells what is valid
   always_ff @(posedge clk_sys)
   begin
      if (doStore)
      begin
         mem[s.wrPtr] <= convData;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence precRunning;
      s.st == smm_pkg::ST_RUN && s.opMode == smm_pkg::OPM_PREC;
   endsequence

   sequence precFinish;
      precRunning ##1 (s.st == smm_pkg::ST_DONE && s.accValid);
   endsequence

   sequence seqRead;
      busRead && smm_pkg::isAutoSeq(s.opMode) && s.st == smm_pkg::ST_RUN;
   endsequence

   a_cal_busy: assert property ((s.st == smm_pkg::ST_CAL) |-> s.busyRdy)
      else $error("busy low during calibration");
   a_ch0_only: assert property ((s.convStart && smm_pkg::isCh0Only(s.opMode)) |-> !s.convChan)
      else $error("channel 1 converted in channel 0 mode");
   a_flag_hold: assert property ((s.alert && !s.aWrite) |=> s.alert)
      else $error("alert dropped without a clear");
   a_stretch_limit: assert property ((s.st != smm_pkg::ST_RUN) |=> !s.sclHold)
      else $error("clock held outside a conversion");
   a_fill_bound: assert property (s.fill <= smm_pkg::BUF_DEPTH)
      else $error("fill count beyond buffer depth");
   a_prec_ready: assert property (precFinish |-> !s.busyRdy)
      else $error("ready not signalled after accumulation");
   a_abort_stop: assert property ((s.aWrite && s.aAddr == smm_pkg::REG_SEQ && hwdata[1] &&
      s.st == smm_pkg::ST_RUN && !manual) |=> (s.st == smm_pkg::ST_IDLE && !s.accValid))
      else $error("abort did not end the sequence");
   a_read_abort: assert property (seqRead |=> s.st == smm_pkg::ST_IDLE ##1 !s.convStart)
      else $error("register read did not stop auto sequence");
   a_prec_zero: assert property ((busRead && haddr[7:6] == smm_pkg::REG_BUF_PAGE &&
      s.opMode == smm_pkg::OPM_PREC) |=> s.hrdata == 32'h0)
      else $error("buffer read not zero in precision mode");
endmodule : smm_sequencer

// File: smm_conv_model.sv
// converter stand-in: answers each convStart with a fixed result per channel
// assumes at most one start in flight; slow adds four cycles of latency
`timescale 1ns/1ns
module smm_conv_model(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic slow,
   input wire logic convStart,
   input wire logic convChan,
   // result
   output logic convDone,
   output logic [11:0] convData
);
   logic [3:0] waitCnt;
   logic chan;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         waitCnt <= 4'h0;
         chan <= 1'b0;
         convDone <= 1'b0;
         convData <= 12'h000;
      end
      else
      begin
         if (convStart)
            waitCnt <= slow ? 4'h5 : 4'h1;
         else if (waitCnt != 4'h0)
            waitCnt <= waitCnt - 4'h1;
         if (convStart)
            chan <= convChan;
         convDone <= (waitCnt == 4'h1);
         // twelve-bit result per channel
         // data toggles outside the done cycle so a stale read never matches
         convData <= (waitCnt == 4'h1) ? (chan ? 12'h0cd : 12'h0ab) : ~convData;
      end
   end
endmodule : smm_conv_model

// File: tb_smm_sequencer.sv
// self-checking bench of the mode sequencer over AHB-Lite and i2c event pulses
// assumes the converter stand-in model; calibration shortened to 8 cycles
`timescale 1ns/1ns
module tb_smm_sequencer;
   logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, i2cAddrRead = 0, i2cStopNack = 0;
   logic sclFall = 0, sclLow = 0, slow = 0, hreadyout, hresp, sclHoldLow, convStart, convChan;
   logic convDone, alertOut, busyRdy;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdS;
   logic [11:0] convData;
   int failures = 0, compares = 0, starts = 0, ch1 = 0;
   logic [7:0] rowA [6] = '{8'h00, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h30};
   logic [31:0] rowE [6] = '{32'h7, 32'h7, 32'h0000ff7f, 32'h0fff0fff, 32'h0, 32'h0};

   smm_sequencer #(.CAL_CYCLES(8)) u_smm_sequencer(.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .i2cAddrRead(i2cAddrRead), .i2cStopNack(i2cStopNack), .sclFall(sclFall), .sclLow(sclLow),
      .sclHoldLow(sclHoldLow), .convStart(convStart), .convChan(convChan), .convDone(convDone),
      .convData(convData), .alertOut(alertOut), .busyRdy(busyRdy));
   smm_conv_model u_smm_conv_model(.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .convStart(convStart),
      .convChan(convChan), .convDone(convDone), .convData(convData));

   always #5 clk_sys = ~clk_sys;
   // read data is latched at the edge itself to avoid racing the design's update
   always @(posedge clk_sys) rdS <= hrdata;
   always @(posedge clk_sys)
   begin
      if (convStart === 1'b1)
      begin
         starts++;
         if (convChan === 1'b1)
            ch1++;
      end
   end

   task automatic print_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task automatic bound(input int k);
      if (k >= 3000)
      begin
         failures++;
         print_verdict();
      end
   endtask : bound

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic hold;
      int k;
      k = 0;
      do
      begin
         @(posedge clk_sys);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 3000);
      bound(k);
   endtask : hold

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hold();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold();
      #1;
      r = rdS;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, r, e);
   endtask : rdc

   task automatic falls(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         sclFall <= 1'b1;
         @(posedge clk_sys);
         sclFall <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : falls

   task automatic addrRead;
      @(posedge clk_sys);
      i2cAddrRead <= 1'b1;
      @(posedge clk_sys);
      i2cAddrRead <= 1'b0;
      #1;
   endtask : addrRead

   task automatic waitStarts(input int n);
      int k;
      k = 0;
      while (starts < n && k < 3000)
      begin
         @(posedge clk_sys);
         k++;
      end
      bound(k);
   endtask : waitStarts

   task automatic waitLow;
      int k;
      k = 0;
      while (busyRdy !== 1'b0 && k < 3000)
      begin
         @(posedge clk_sys);
         k++;
      end
      bound(k);
   endtask : waitLow

   initial
   begin
      int s0;
      int c0;
      logic [31:0] r;
      repeat (2) @(posedge clk_sys);
      chk("busyRdy in reset", busyRdy, 1);
      chk("hresp okay", hresp, 0);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk("busyRdy calibrating", busyRdy, 1);
      repeat (10) @(posedge clk_sys);
      #1 chk("busyRdy after cal", busyRdy, 0);
      rdc("status idle", smm_pkg::REG_STATUS, 32'h1);
      rdc("mode after cal", smm_pkg::REG_MODE, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         wr(rowA[i], 32'hffffffff);
         rdc("register row", rowA[i], rowE[i]);
      end
      wr(smm_pkg::REG_MODE, 32'h0);
      wr(smm_pkg::REG_CFG, 32'h0);
      addrRead();
      sclLow <= 1'b1;
      chk("manual start", convStart, 1);
      chk("manual channel", convChan, 0);
      repeat (5) @(posedge clk_sys);
      #1 chk("stretch short low", sclHoldLow, 1);
      repeat (190) @(posedge clk_sys);
      #1 chk("stretch released", sclHoldLow, 0);
      sclLow <= 1'b0;
      wr(smm_pkg::REG_MODE, 32'h7);
      rdc("mode locked in stream", smm_pkg::REG_MODE, 32'h0);
      falls(17);
      chk("starts after 17", starts, 1);
      falls(1);
      chk("starts after 18", starts, 2);
      @(posedge clk_sys);
      i2cStopNack <= 1'b1;
      @(posedge clk_sys);
      i2cStopNack <= 1'b0;
      wr(smm_pkg::REG_MODE, 32'h4);
      rdc("mode after stop", smm_pkg::REG_MODE, 32'h4);
      // manual auto sequence over both channels; the start bit only arms
      wr(smm_pkg::REG_CFG, 32'h3);
      s0 = starts;
      wr(smm_pkg::REG_SEQ, 32'h1);
      repeat (5) @(posedge clk_sys);
      #1 chk("armed only", starts - s0, 0);
      addrRead();
      chk("first channel", convChan, 0);
      falls(18);
      chk("second channel", convChan, 1);
      rdc("sequence running", smm_pkg::REG_SEQ, 32'h3);
      falls(20);
      chk("read stops sequence", starts - s0, 2);
      // precision, channel 0, divider 7
      wr(smm_pkg::REG_MODE, 32'h7);
      wr(smm_pkg::REG_CFG, 32'h0741);
      s0 = starts;
      wr(smm_pkg::REG_SEQ, 32'h1);
      repeat (2) @(posedge clk_sys);
      #1 chk("busy during accumulation", busyRdy, 1);
      waitLow();
      chk("precision count", starts - s0, 16);
      rdc("acc ch0", smm_pkg::REG_ACC, 32'h00000ab0);
      rdc("buffer in precision", 8'h40, 32'h0);
      bus(1'b0, smm_pkg::REG_STATUS, 32'h0, r);
      chk("acc valid", r[8], 1);
      chk("state done", r[1:0], 3);
      // both channels with a slow converter
      slow <= 1'b1;
      wr(smm_pkg::REG_CFG, 32'h0743);
      s0 = starts;
      c0 = ch1;
      wr(smm_pkg::REG_SEQ, 32'h1);
      waitLow();
      chk("dual count", starts - s0, 32);
      chk("ch1 share", ch1 - c0, 16);
      rdc("acc both", smm_pkg::REG_ACC, 32'h0cd00ab0);
      wr(smm_pkg::REG_SEQ, 32'h1);
      repeat (20) @(posedge clk_sys);
      wr(smm_pkg::REG_SEQ, 32'h2);
      repeat (2) @(posedge clk_sys);
      #1 chk("busy dropped on abort", busyRdy, 0);
      bus(1'b0, smm_pkg::REG_STATUS, 32'h0, r);
      chk("aborted acc invalid", r[8], 0);
      // autonomous start burst
      slow <= 1'b0;
      wr(smm_pkg::REG_MODE, 32'h6);
      wr(smm_pkg::REG_BUFMODE, 32'h1);
      wr(smm_pkg::REG_CFG, 32'h0701);
      s0 = starts;
      wr(smm_pkg::REG_SEQ, 32'h1);
      waitStarts(s0 + 16);
      repeat (40) @(posedge clk_sys);
      chk("burst stops full", starts - s0, 16);
      bus(1'b0, smm_pkg::REG_STATUS, 32'h0, r);
      chk("burst fill", r[6:2], 16);
      rdc("last entry", 8'h7c, 32'h0ab);
      // stop burst with window compare on channel 0
      wr(smm_pkg::REG_BUFMODE, 32'h0);
      wr(smm_pkg::REG_TH0, 32'h00800010);
      wr(smm_pkg::REG_CFG, 32'h0715);
      s0 = starts;
      wr(smm_pkg::REG_SEQ, 32'h1);
      waitStarts(s0 + 20);
      chk("alert raised", alertOut, 1);
      wr(smm_pkg::REG_SEQ, 32'h2);
      repeat (10) @(posedge clk_sys);
      s0 = starts;
      repeat (40) @(posedge clk_sys);
      chk("abort stops burst", starts - s0, 0);
      rdc("high flag latched", smm_pkg::REG_HIGHF, 32'h1);
      rdc("low flag clear", smm_pkg::REG_LOWF, 32'h0);
      wr(smm_pkg::REG_HIGHF, 32'h3);
      repeat (2) @(posedge clk_sys);
      #1 chk("alert cleared", alertOut, 0);
      // pre-alert over both channels; the low threshold is raised mid-run to trip channel 1
      wr(smm_pkg::REG_BUFMODE, 32'h4);
      wr(smm_pkg::REG_TH1, 32'h0fff0000);
      wr(smm_pkg::REG_CFG, 32'h071b);
      s0 = starts;
      wr(smm_pkg::REG_SEQ, 32'h1);
      waitStarts(s0 + 20);
      wr(smm_pkg::REG_TH1, 32'h0fff0fff);
      repeat (40) @(posedge clk_sys);
      c0 = starts;
      repeat (40) @(posedge clk_sys);
      chk("pre-alert stops on flag", starts - c0, 0);
      chk("pre-alert ran past 16", starts - s0 > 16, 1);
      bus(1'b0, smm_pkg::REG_STATUS, 32'h0, r);
      chk("pre-alert fill", r[6:2], 16);
      chk("pre-alert done", r[1:0], 3);
      rdc("channel 1 low flag", smm_pkg::REG_LOWF, 32'h2);
      // post-alert on channel 0; the high threshold drops below the result after five starts
      wr(smm_pkg::REG_BUFMODE, 32'h6);
      wr(smm_pkg::REG_TH0, 32'h0fff0000);
      wr(smm_pkg::REG_CFG, 32'h0715);
      s0 = starts;
      wr(smm_pkg::REG_SEQ, 32'h1);
      waitStarts(s0 + 5);
      wr(smm_pkg::REG_TH0, 32'h00800010);
      repeat (200) @(posedge clk_sys);
      c0 = starts;
      repeat (40) @(posedge clk_sys);
      chk("post-alert stops", starts - c0, 0);
      chk("post-alert converted before flag", starts - s0 > 16, 1);
      bus(1'b0, smm_pkg::REG_STATUS, 32'h0, r);
      chk("post-alert fill", r[6:2], 16);
      chk("post-alert trigger", r[7], 1);
      // reset after the post-alert run has stopped: latched flags drop and calibration runs again
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      #1 chk("alert in reset", alertOut, 0);
      chk("busy in reset", busyRdy, 1);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk_sys);
      #1 chk("busy after recalibration", busyRdy, 0);
      rdc("mode after recalibration", smm_pkg::REG_MODE, 32'h0);
      print_verdict();
   end
endmodule : tb_smm_sequencer
